// ==== core/bbl_host.sv ====
// Host controller that programs or erases flash blocks, boot block too.
// Assumes external level shifters turn the unlock requests into the
// high-voltage level on the powerdown or output-enable pin.
`timescale 1ns/100ps
`include "bbl_params.svh"
module bbl_host
  import bbl_pkg::*;
#(
  parameter int OE_HOLD_CYC = `BBL_OE_HOLD_CYC,
  parameter int BUS_CYC = `BBL_BUS_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [16:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic powerdown_pin_n,
  output logic pd_unlock_high_voltage,
  output logic oe_unlock_high_voltage
);
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_PRE_WAIT,
    ST_SETUP,
    ST_SECOND,
    ST_POST_WAIT,
    ST_POLL_CMD,
    ST_POLL_RD,
    ST_CLEAR,
    ST_DONE
  } bbl_state_t;

  bbl_state_t state;
  logic [16:0] tgt_addr;
  logic [7:0] tgt_data;
  logic op_erase;
  logic op_boot;
  logic use_oe;
  logic [7:0] flash_sr;
  logic busy;
  logic err;
  logic blocked;
  logic [15:0] hold_cnt;
  logic bus_start;
  logic bus_done;
  logic [7:0] bus_rdata;
  bbl_bus_req_t bus_req;
  logic oe_strobe_n;
  logic go_wr;
  logic clr_wr;
  logic bus_go;
  logic oe_boot;
  logic hold_met;
  logic poll_done;
  logic clear_done;

  function automatic logic sr_has_error(input logic [7:0] sr);
    sr_has_error = sr[`BBL_SR_SUPPLY_LOW] | sr[`BBL_SR_PROG_ERR]
                 | sr[`BBL_SR_ERASE_ERR];
  endfunction

  // States that own a flash bus cycle
  function automatic logic is_bus_state(input bbl_state_t s);
    is_bus_state = s == ST_SETUP || s == ST_SECOND || s == ST_POLL_CMD
                   || s == ST_POLL_RD || s == ST_CLEAR;
  endfunction

  // States in which output-enable sits at the unlock level
  function automatic logic in_oe_window(input bbl_state_t s);
    in_oe_window = s == ST_PRE_WAIT || s == ST_SETUP || s == ST_SECOND
                   || s == ST_POST_WAIT;
  endfunction

  assign go_wr = reg_wr && reg_addr == `BBL_REG_CTRL
                 && reg_wdata[`BBL_CTRL_GO];
  assign clr_wr = reg_wr && reg_addr == `BBL_REG_CTRL
                  && reg_wdata[`BBL_CTRL_CLEAR];
  assign oe_boot = op_boot && use_oe;
  // Settle wait applies only to boot block work unlocked through OE
  assign hold_met = !oe_boot || hold_cnt >= 16'(OE_HOLD_CYC);
  assign poll_done = state == ST_POLL_RD && bus_done;
  assign clear_done = state == ST_CLEAR && bus_done;

  // Software view, one index per register:
  //   0 control: b0 go, b1 erase, b2 boot block, b3 unlock via OE, b4 clear
  //   1 target address, 2 program data (low byte)
  //   3 status: b0 busy, b1 error seen, b2 new attempts refused
  //   4 last flash status polled, 80H after reset or clear
  // Setup freezes while busy so a running sequence keeps its target
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tgt_addr <= 17'h00000;
      tgt_data <= 8'h00;
      op_erase <= 1'b0;
      op_boot <= 1'b0;
      use_oe <= 1'b0;
    end else if (reg_wr && !busy) begin
      if (reg_addr == `BBL_REG_ADDR) begin
        tgt_addr <= reg_wdata[16:0];
      end
      if (reg_addr == `BBL_REG_DATA) begin
        tgt_data <= reg_wdata[7:0];
      end
      if (reg_addr == `BBL_REG_CTRL) begin
        op_erase <= reg_wdata[`BBL_CTRL_ERASE];
        op_boot <= reg_wdata[`BBL_CTRL_BOOT];
        use_oe <= reg_wdata[`BBL_CTRL_USE_OE];
      end
    end
  end

  // Read data stands one cycle only and is zero otherwise
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `BBL_REG_ADDR: reg_rdata <= {15'h0000, tgt_addr};
        `BBL_REG_DATA: reg_rdata <= {24'h000000, tgt_data};
        `BBL_REG_CTRL: reg_rdata <= {28'h0000000, use_oe, op_boot,
                                     op_erase, 1'b0};
        `BBL_REG_STAT: reg_rdata <= {29'h00000000, blocked, err, busy};
        `BBL_REG_FLASH_SR: reg_rdata <= {24'h000000, flash_sr};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Sequencer issuing bus cycles
  assign bus_go = is_bus_state(state);
  // Held off in the done cycle so one state never starts two cycles
  assign bus_start = bus_go && !bus_done;

  // Default is the read-status command; the poll states rely on it
  always_comb begin
    bus_req.addr = tgt_addr;
    bus_req.data = `BBL_CMD_READ_STATUS;
    bus_req.we = 1'b1;
    unique case (state)
      ST_SETUP: bus_req.data = op_erase ? `BBL_CMD_ERASE_SETUP
                                        : `BBL_CMD_PROG_SETUP;
      ST_SECOND: bus_req.data = op_erase ? `BBL_CMD_ERASE_CONFIRM
                                         : tgt_data;
      ST_POLL_RD: bus_req.we = 1'b0;
      ST_CLEAR: bus_req.data = `BBL_CMD_CLEAR_STATUS;
      default: bus_req.data = `BBL_CMD_READ_STATUS;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      hold_cnt <= 16'h0000;
      busy <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          hold_cnt <= 16'h0000;
          if (go_wr && !blocked) begin
            busy <= 1'b1;
            state <= ST_PRE_WAIT;
          end
        end
        ST_PRE_WAIT: begin
          // Unlock is driven here; OE path needs a settle time
          hold_cnt <= hold_cnt + 16'h0001;
          if (hold_met) begin
            hold_cnt <= 16'h0000;
            state <= ST_SETUP;
          end
        end
        ST_SETUP: if (bus_done) state <= ST_SECOND;
        ST_SECOND: if (bus_done) state <= ST_POST_WAIT;
        ST_POST_WAIT: begin
          hold_cnt <= hold_cnt + 16'h0001;
          if (hold_met) begin
            state <= ST_POLL_CMD;
          end
        end
        ST_POLL_CMD: if (bus_done) state <= ST_POLL_RD;
        ST_POLL_RD: begin
          if (bus_done) begin
            if (bus_rdata[`BBL_SR_READY]) begin
              state <= ST_DONE;
            end else begin
              // Still busy: write read-status again and re-read
              state <= ST_POLL_CMD;
            end
          end
        end
        ST_CLEAR: if (bus_done) state <= ST_IDLE;
        ST_DONE: begin
          busy <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
      // Clear outranks GO in one write: status is clean before any retry
      if (clr_wr && state == ST_IDLE) begin
        busy <= 1'b1;
        state <= ST_CLEAR;
      end
      if (clear_done) begin
        busy <= 1'b0;
      end
    end
  end

  // Flash status copy; reflects reset value until first poll
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flash_sr <= `BBL_SR_RESET;
    end else if (poll_done) begin
      flash_sr <= bus_rdata;
    end else if (clear_done) begin
      flash_sr <= `BBL_SR_RESET;
    end
  end

  // Sticky error: refuses new attempts until clear, lock shows as op error
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      err <= 1'b0;
      blocked <= 1'b0;
    end else if (poll_done && bus_rdata[`BBL_SR_READY]) begin
      err <= sr_has_error(bus_rdata);
      blocked <= sr_has_error(bus_rdata);
    end else if (clear_done) begin
      err <= 1'b0;
      blocked <= 1'b0;
    end
  end

  // PD unlock held from before setup until status confirms completion; OE unlock drops after the post-write wait
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pd_unlock_high_voltage <= 1'b0;
      oe_unlock_high_voltage <= 1'b0;
    end else begin
      pd_unlock_high_voltage <= op_boot && !use_oe && busy
                                && state != ST_DONE
                                && state != ST_CLEAR;
      oe_unlock_high_voltage <= oe_boot
                                && in_oe_window(state);
    end
  end

  // Powerdown stays inactive once out of reset
  // Deep powerdown is entered only while nrst is low; the pin only follows reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      powerdown_pin_n <= 1'b0;
    end else begin
      powerdown_pin_n <= 1'b1;
    end
  end

  // Read strobe blocked while OE is at unlock level
  assign flash_oe_n = oe_strobe_n | oe_unlock_high_voltage;

  bbl_bus_cycle #(
    .BUS_CYC(BUS_CYC)
  ) u_bus (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(bus_start),
    .req(bus_req),
    .done(bus_done),
    .rdata(bus_rdata),
    .addr_pin(flash_addr),
    .dq_out(flash_dq_out),
    .dq_oe(flash_dq_oe),
    .dq_in(flash_dq_in),
    .ce_n(flash_ce_n),
    .we_n(flash_we_n),
    .oe_strobe_n(oe_strobe_n)
  );
endmodule // bbl_host

// ==== core/bbl_params.svh ====
// Constants for the boot block lockout host controller.
// Assumes a 200 MHz ref_clk; included by the modules, not by the package.
`ifndef BBL_PARAMS_SVH
`define BBL_PARAMS_SVH

`define BBL_CLK_PERIOD_PS 5000
`define BBL_CMD_PROG_SETUP 8'h40
`define BBL_CMD_ERASE_SETUP 8'h20
`define BBL_CMD_ERASE_CONFIRM 8'hD0
`define BBL_CMD_READ_STATUS 8'h70
`define BBL_CMD_CLEAR_STATUS 8'h50
`define BBL_CMD_READ_ARRAY 8'hFF
`define BBL_SR_RESET 8'h80
`define BBL_SR_READY 7
`define BBL_SR_ERASE_ERR 5
`define BBL_SR_PROG_ERR 4
`define BBL_SR_SUPPLY_LOW 3
`define BBL_OE_HOLD_NS 480
`define BBL_OE_HOLD_CYC ((`BBL_OE_HOLD_NS * 1000 + `BBL_CLK_PERIOD_PS - 1) / `BBL_CLK_PERIOD_PS)
`define BBL_BUS_CYC 16
`define BBL_REG_CTRL 4'h0
`define BBL_REG_ADDR 4'h1
`define BBL_REG_DATA 4'h2
`define BBL_REG_STAT 4'h3
`define BBL_REG_FLASH_SR 4'h4
`define BBL_CTRL_GO 0
`define BBL_CTRL_ERASE 1
`define BBL_CTRL_BOOT 2
`define BBL_CTRL_USE_OE 3
`define BBL_CTRL_CLEAR 4

`endif

// ==== core/bbl_pkg.sv ====
// Types for the boot block lockout host controller.
// Constants live in bbl_params.svh.
package bbl_pkg;
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
    logic we;
  } bbl_bus_req_t;

  typedef enum logic [1:0] {
    BBL_UNLOCK_NONE,
    BBL_UNLOCK_PD,
    BBL_UNLOCK_OE
  } bbl_unlock_t;
endpackage

// ==== core/bbl_bus_cycle.sv ====
// One parallel bus cycle toward the flash: write or read.
// Assumes the flash answers within BUS_CYC clocks; data pins two-way.
`timescale 1ns/100ps
`include "bbl_params.svh"
module bbl_bus_cycle
  import bbl_pkg::*;
#(
  parameter int BUS_CYC = `BBL_BUS_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic start,
  input wire bbl_bus_req_t req,
  output logic done,
  output logic [7:0] rdata,
  output logic [16:0] addr_pin,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic [7:0] dq_in,
  output logic ce_n,
  output logic we_n,
  output logic oe_strobe_n
);
  logic [7:0] cnt;
  logic busy;
  logic is_wr;
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      is_wr <= 1'b0;
      addr_pin <= 17'h00000;
      dq_out <= 8'h00;
    end else if (start && !busy) begin
      busy <= 1'b1;
      cnt <= 8'h00;
      is_wr <= req.we;
      addr_pin <= req.addr;
      dq_out <= req.data;
    end else if (busy) begin
      cnt <= cnt + 8'h01;
      if (cnt == 8'(BUS_CYC - 1)) begin
        busy <= 1'b0;
      end
    end
  end

  // Write strobe stays off for the first and last two cycles, read strobe for the first and last one, for setup and hold
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_strobe_n <= 1'b1;
      dq_oe <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      ce_n <= !(busy && cnt < 8'(BUS_CYC - 1));
      we_n <= !(busy && is_wr && cnt >= 8'h02 && cnt < 8'(BUS_CYC - 2));
      oe_strobe_n <= !(busy && !is_wr && cnt >= 8'h01
                       && cnt < 8'(BUS_CYC - 1));
      dq_oe <= busy && is_wr;
      done <= busy && cnt == 8'(BUS_CYC - 1);
      if (busy && !is_wr && cnt == 8'(BUS_CYC - 2)) begin
        rdata <= dq_s2;
      end
    end
  end
endmodule // bbl_bus_cycle

// ==== tb/bbl_host_chk_sva.sv ====
// Port assertions for bbl_host.
// Bound to every bbl_host; watches its flash pins only.
`timescale 1ns/100ps
module bbl_host_chk #(
  parameter int OE_HOLD_CYC = 96,
  parameter int BUS_CYC = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [16:0] flash_addr,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic powerdown_pin_n,
  input wire logic pd_unlock_high_voltage,
  input wire logic oe_unlock_high_voltage
);
  localparam int WE_MAX = BUS_CYC;
  int oe_up;
  int we_hi;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      oe_up <= 0;
      we_hi <= 0;
    end else begin
      oe_up <= oe_unlock_high_voltage ? oe_up + 1 : 0;
      we_hi <= flash_we_n ? we_hi + 1 : 0;
    end
  end
  pd_awake_a: assert property ($past(nrst) |-> powerdown_pin_n)
    else $error("powerdown pin low");
  we_sel_a: assert property (!flash_we_n |->
    !flash_ce_n && flash_dq_oe) else $error("write unselected");
  one_unlock_a: assert property (pd_unlock_high_voltage |->
    !oe_unlock_high_voltage && powerdown_pin_n) else $error("two unlocks");
  oe_pre_a: assert property ($fell(flash_we_n) && oe_unlock_high_voltage
    |-> oe_up >= OE_HOLD_CYC) else $error("unlock too late");
  oe_post_a: assert property ($fell(oe_unlock_high_voltage) |->
    we_hi >= OE_HOLD_CYC) else $error("unlock dropped early");
  wr_hold_a: assert property ($fell(flash_we_n) |->
    ($stable(flash_addr) && !flash_we_n) [*8]) else $error("write unstable");
  we_len_a: assert property ($fell(flash_we_n) |->
    ##[1:WE_MAX] flash_we_n) else $error("write strobe too long");
  pd_hold_a: assert property ($fell(pd_unlock_high_voltage) |->
    flash_ce_n) else $error("unlock dropped in cycle");
endmodule // bbl_host_chk

bind bbl_host bbl_host_chk #(.OE_HOLD_CYC(OE_HOLD_CYC), .BUS_CYC(BUS_CYC))
  chk_u (.ref_clk, .nrst, .flash_addr, .flash_dq_oe, .flash_ce_n,
  .flash_we_n, .powerdown_pin_n, .pd_unlock_high_voltage,
  .oe_unlock_high_voltage);

// ==== tb/bbl_flash_model.sv ====
// Behavioural flash on the host pins: commands, status, boot lockout.
// Unlock flags stand for high voltage on powerdown or output-enable.
`timescale 1ns/100ps
module bbl_flash_model #(
  parameter int BUSY = 6
) (
  input wire logic ref_clk,
  input wire logic [16:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  output logic [7:0] flash_dq_in,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic powerdown_pin_n,
  input wire logic pd_unlock_high_voltage,
  input wire logic oe_unlock_high_voltage,
  input wire logic supply_low
);
  logic [7:0] sr = 8'h80, mem = 8'h00;
  logic [16:0] sa = 17'h0;
  logic [1:0] mode = 2'h0;
  logic we_q = 1'b1;
  logic lock, miss;
  int cnt = 0, ops = 0, bad = 0;
  // Released bus reads back inverted, never a stale match
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? sr : ~sr;
  // Boot block is the top 8 KB; unlock taken as the write lands
  assign lock = flash_addr[16:13] == 4'hF &&
    !(pd_unlock_high_voltage || oe_unlock_high_voltage);
  assign miss = flash_addr !== sa ||
    (mode == 2'h2 && flash_dq_out !== 8'hD0);
  always @(posedge ref_clk or negedge powerdown_pin_n) begin
    if (!powerdown_pin_n) begin
      sr <= 8'h80;
      mode <= 2'h0;
      cnt <= 0;
    end else begin
      we_q <= flash_we_n;
      if (cnt == 1) sr[7] <= 1'b1;
      if (cnt > 0) cnt <= cnt - 1;
      if (flash_we_n && !we_q && !flash_ce_n) begin
        mode <= 2'h0;
        sa <= flash_addr;
        if (mode == 2'h0) begin
          if (flash_dq_out == 8'h40) mode <= 2'h1;
          if (flash_dq_out == 8'h20) mode <= 2'h2;
          if (flash_dq_out == 8'h50) sr[5:3] <= 3'h0;
        end else if (miss) begin
          bad <= bad + 1;
        end else if (supply_low || sr[3]) begin
          sr[3] <= 1'b1;
        end else if (lock) begin
          sr[mode == 2'h1 ? 4 : 5] <= 1'b1;
        end else begin
          sr[7] <= 1'b0;
          cnt <= BUSY;
          ops <= ops + 1;
          mem <= flash_dq_out;
        end
      end
    end
  end
endmodule // bbl_flash_model

// ==== tb/test_bbl_host.sv ====
// Self-checking bench: bbl_host driving the flash model.
// Short unlock hold of 4 cycles keeps the run brief.
`timescale 1ns/100ps
module test_bbl_host;
  logic ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic supply_low = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, st;
  logic [16:0] flash_addr;
  logic [7:0] flash_dq_out, flash_dq_in;
  logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, powerdown_pin_n;
  logic pd_unlock_high_voltage, oe_unlock_high_voltage;
  int err_count = 0, tests_run = 0;
  always #2.5 ref_clk = ~ref_clk;
  bbl_host #(.OE_HOLD_CYC(4)) dut_u (.ref_clk, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_addr, .flash_dq_out,
    .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_we_n, .flash_oe_n,
    .powerdown_pin_n, .pd_unlock_high_voltage, .oe_unlock_high_voltage);
  // Flash stays busy long enough that the first status poll sees busy
  bbl_flash_model #(.BUSY(60)) flash_u (.ref_clk, .flash_addr, .flash_dq_out,
    .flash_dq_in, .flash_ce_n, .flash_we_n, .flash_oe_n, .powerdown_pin_n,
    .pd_unlock_high_voltage, .oe_unlock_high_voltage, .supply_low);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic see(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
    if (e !== 32'hFFFFFFFF) chk(st, e);
  endtask
  task automatic idle();
    for (int i = 0; i < 3000; i++) begin
      see(4'h3, 32'hFFFFFFFF);
      if (st[0] === 1'b0) return;
    end
    err_count++;
    $display("[ERR] %0t controller stuck busy", $time);
    final_report();
  endtask
  task automatic op(input logic [16:0] a, input logic [4:0] c);
    wr(4'h1, {15'h0, a});
    wr(4'h2, 32'h5A);
    wr(4'h0, {27'h0, c});
    idle();
  endtask
  task automatic t_plain();
    see(4'h4, 32'h80);
    see(4'h3, 32'h0);
    see(4'hF, 32'h0);
    op(17'h00100, 5'h01);
    chk(st, 32'h0);
    chk(flash_u.mem, 32'h5A);
  endtask
  task automatic t_locked();
    op(17'h1E000, 5'h01);
    chk(st, 32'h6);
    see(4'h4, 32'h90);
    wr(4'h0, 32'h3);
    see(4'h3, 32'h6);
    wr(4'h0, 32'h10);
    idle();
    chk(st, 32'h0);
    op(17'h1E000, 5'h03);
    see(4'h4, 32'hA0);
    wr(4'h0, 32'h10);
    idle();
    chk(flash_u.ops, 32'h1);
  endtask
  task automatic t_unlock();
    op(17'h1E010, 5'h05);
    chk(st, 32'h0);
    op(17'h1F000, 5'h0F);
    chk(st, 32'h0);
    see(4'h4, 32'h80);
    chk(flash_u.ops, 32'h3);
    chk(flash_u.bad, 32'h0);
  endtask
  task automatic t_supply();
    supply_low <= 1'b1;
    op(17'h00200, 5'h01);
    chk(st, 32'h6);
    see(4'h4, 32'h88);
    @(posedge ref_clk);
    supply_low <= 1'b0;
    nrst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    chk(flash_u.sr, 32'h80);
    see(4'h4, 32'h80);
    op(17'h00200, 5'h03);
    chk(st, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_plain();
    t_locked();
    t_unlock();
    t_supply();
    final_report();
  end
endmodule // test_bbl_host
